// ---- rtl/tlvi_pkg.sv ----
// constants, types and vector table of the two-level vectored interrupt unit
//
// Notes on behaviour
// - seven request sources, two priority levels
// - disabled source never armed for a call; one armed earlier still fires unless a poll precedes the boundary
// - pin0 0003h, timer0 000Bh, pin1 0013h
// - timer1 001Bh, two-wire port 003Bh
// - uart pair 0023h, timer2 pair 002Bh
// - same level: fixed order pin0 first, two-wire last
// - running service preempted only by higher level
// - no call during equal or higher service
// - return from service releases the active level
// - flags set whether or not enabled
// - flags sampled once per machine cycle, then polled
// - long call forced on the following instruction cycle
// - master gate bit 7 blocks or allows all
// - main enables: bits 5..0 per source
// - second enable bit 1: two-wire port
// - main levels same positions, 1 is high
// - second level bit 1: two-wire port level
package tlvi_pkg;
  localparam int NSRC = 7;
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_ENA_MAIN = 8'ha8;
  localparam logic [7:0] IDX_ENA_EXT = 8'ha9;
  localparam logic [7:0] IDX_LVL_MAIN = 8'hb8;
  localparam logic [7:0] IDX_LVL_EXT = 8'hb9;
  localparam logic [7:0] IDX_STATUS = 8'hba;
  localparam logic [7:0] IDX_SAMPLES = 8'hbb;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int MASTER_BIT = 7;
  localparam int EXT_BIT = 1;
  localparam logic [7:0] MAIN_MASK = 8'hbf;
  localparam logic [7:0] LVL_MASK = 8'h3f;
  localparam logic [7:0] EXT_MASK = 8'h02;
  localparam logic [15:0] VEC_PIN0 = 16'h0003;
  localparam logic [15:0] VEC_TIMER0 = 16'h000b;
  localparam logic [15:0] VEC_PIN1 = 16'h0013;
  localparam logic [15:0] VEC_TIMER1 = 16'h001b;
  localparam logic [15:0] VEC_UART = 16'h0023;
  localparam logic [15:0] VEC_TIMER2 = 16'h002b;
  localparam logic [15:0] VEC_TWOWIRE = 16'h003b;
  typedef logic [2:0] tlvi_src_t;
  typedef enum {TLVI_IDLE, TLVI_ARMED} tlvi_state_e;

  function automatic logic [15:0] tlvi_vector(input tlvi_src_t s);
    case (s)
      3'h0: return VEC_PIN0;
      3'h1: return VEC_TIMER0;
      3'h2: return VEC_PIN1;
      3'h3: return VEC_TIMER1;
      3'h4: return VEC_UART;
      3'h5: return VEC_TIMER2;
      default: return VEC_TWOWIRE;
    endcase
  endfunction : tlvi_vector
endpackage : tlvi_pkg

// ---- rtl/tlvi_req_if.sv ----
// carrier between the unit, its flag sampler and its arbiter
`timescale 1ns/1ps
`default_nettype none
interface tlvi_req_if;
  logic [6:0] sample;
  logic [6:0] enable;
  logic [6:0] high;
  logic win_valid;
  logic [2:0] win_src;
  logic win_high;
  modport smp (output sample);
  modport arb (input sample, input enable, input high,
    output win_valid, output win_src, output win_high);
  modport core (input sample, output enable, output high,
    input win_valid, input win_src, input win_high);
endinterface : tlvi_req_if
`default_nettype wire

// ---- rtl/tlvi_sampler.sv ----
// once-per-machine-cycle sampling of the peripheral request flags
`timescale 1ns/1ps
`default_nettype none
module tlvi_sampler
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic strobe,
  input wire logic [8:0] flags,
  tlvi_req_if.smp req
);
  import tlvi_pkg::*;
  logic [6:0] sample_reg;
  logic [6:0] sample_next;

  // flags arrive unqualified by enables, so a disabled source is still seen
  always_comb
  begin
    sample_next = {flags[8], flags[7] | flags[6], flags[5] | flags[4], flags[3:0]};
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sample_reg <= 7'h00;
    end
    else if (strobe)
    begin
      sample_reg <= sample_next;
    end
  end

  assign req.sample = sample_reg;
endmodule : tlvi_sampler
`default_nettype wire

// ---- rtl/tlvi_arb.sv ----
// two-level fixed-order pick among sampled, enabled requests
`timescale 1ns/1ps
`default_nettype none
module tlvi_arb
(
  tlvi_req_if.arb req
);
  import tlvi_pkg::*;
  logic [6:0] hi_pend;
  logic [6:0] lo_pend;

  // lowest index wins: pin0 first, two-wire port last
  function automatic tlvi_src_t first_set(input logic [6:0] v);
    tlvi_src_t r;
    r = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : first_set

  always_comb
  begin
    hi_pend = req.sample & req.enable & req.high;
    lo_pend = req.sample & req.enable & ~req.high;
    req.win_valid = |(hi_pend | lo_pend);
    req.win_high = |hi_pend;
    req.win_src = (|hi_pend) ? first_set(hi_pend) : first_set(lo_pend);
  end
endmodule : tlvi_arb
`default_nettype wire

// ---- rtl/tlvi_unit.sv ----
// top of the two-level vectored interrupt unit with its register slave
`timescale 1ns/1ps
`default_nettype none
module tlvi_unit
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [tlvi_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic PIN0_REQUEST_FLAG,
  input wire logic TIMER0_OVERFLOW_FLAG,
  input wire logic PIN1_REQUEST_FLAG,
  input wire logic TIMER1_OVERFLOW_FLAG,
  input wire logic RX_DONE_FLAG,
  input wire logic TX_DONE_FLAG,
  input wire logic TIMER2_OVERFLOW_FLAG,
  input wire logic TIMER2_EXTERNAL_FLAG,
  input wire logic TWO_WIRE_PORT_FLAG,
  input wire logic MACHINE_CYCLE,
  input wire logic INSTR_BOUNDARY,
  input wire logic RETURN_FROM_SERVICE,
  output logic LONG_CALL,
  output logic [15:0] VECTOR,
  output logic [6:0] SOURCE_ACK,
  output logic IN_SERVICE_HIGH,
  output logic IN_SERVICE_LOW
);
  import tlvi_pkg::*;

  // ==========================================================
  // declarations
  tlvi_req_if req ();
  logic [7:0] ena_main_reg;
  logic [7:0] ena_ext_reg;
  logic [7:0] lvl_main_reg;
  logic [7:0] lvl_ext_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic poll_reg;
  tlvi_state_e state_reg;
  tlvi_state_e state_next;
  tlvi_src_t pend_src_reg;
  logic pend_high_reg;
  logic ins_hi_reg;
  logic ins_lo_reg;
  logic ins_hi_next;
  logic ins_lo_next;
  logic call_reg;
  logic [15:0] vector_reg;
  logic [6:0] ack_reg;
  tlvi_src_t last_src_reg;
  logic bus_req;
  logic bus_take;
  logic bus_wr;
  logic [7:0] idx;
  logic allowed;
  logic fire;

  // ==========================================================
  // flag sampling and arbitration
  tlvi_sampler u_sampler
  (
    .clk(CLK),
    .rstn(RSTN),
    .strobe(MACHINE_CYCLE),
    .flags({TWO_WIRE_PORT_FLAG, TIMER2_EXTERNAL_FLAG, TIMER2_OVERFLOW_FLAG,
      TX_DONE_FLAG, RX_DONE_FLAG, TIMER1_OVERFLOW_FLAG, PIN1_REQUEST_FLAG,
      TIMER0_OVERFLOW_FLAG, PIN0_REQUEST_FLAG}),
    .req(req.smp)
  );

  tlvi_arb u_arb
  (
    .req(req.arb)
  );

  // the master gate folds into every per-source enable
  always_comb
  begin
    req.enable = ena_main_reg[MASTER_BIT] ?
      {ena_ext_reg[EXT_BIT], ena_main_reg[5:0]} : 7'h00;
    req.high = {lvl_ext_reg[EXT_BIT], lvl_main_reg[5:0]};
  end

  // ==========================================================
  // register slave
  // one wait cycle per access; read data is taken on the edge that drops the wait, a write one edge later
  always_comb
  begin
    bus_req = READ | WRITE;
    bus_take = bus_req & ~wait_reg;
    bus_wr = WRITE & bus_take & BYTEENABLE[0];
    idx = ADDRESS[ADDR_W-1:2];
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      wait_reg <= 1'b1;
    end
    else
    begin
      wait_reg <= ~(bus_req & wait_reg);
    end
  end

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (idx)
      IDX_ENA_MAIN: rdata_next[7:0] = ena_main_reg;
      IDX_ENA_EXT: rdata_next[7:0] = ena_ext_reg;
      IDX_LVL_MAIN: rdata_next[7:0] = lvl_main_reg;
      IDX_LVL_EXT: rdata_next[7:0] = lvl_ext_reg;
      IDX_STATUS:
      begin
        rdata_next[0] = ins_lo_reg;
        rdata_next[1] = ins_hi_reg;
        rdata_next[2] = (state_reg == TLVI_ARMED);
        rdata_next[6:4] = last_src_reg;
      end
      IDX_SAMPLES: rdata_next[6:0] = req.sample;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else if (READ & wait_reg)
    begin
      rdata_reg <= rdata_next;
    end
  end

  // reserved bits are masked so they always read zero
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ena_main_reg <= REG_RESET;
      ena_ext_reg <= REG_RESET;
      lvl_main_reg <= REG_RESET;
      lvl_ext_reg <= REG_RESET;
    end
    else if (bus_wr)
    begin
      case (idx)
        IDX_ENA_MAIN: ena_main_reg <= WRITEDATA[7:0] & MAIN_MASK;
        IDX_ENA_EXT: ena_ext_reg <= WRITEDATA[7:0] & EXT_MASK;
        IDX_LVL_MAIN: lvl_main_reg <= WRITEDATA[7:0] & LVL_MASK;
        IDX_LVL_EXT: lvl_ext_reg <= WRITEDATA[7:0] & EXT_MASK;
        default:
        begin
        end
      endcase
    end
  end

  // ==========================================================
  // poll and call sequencing
  // polling one cycle after the sample gives the arbiter settled inputs
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      poll_reg <= 1'b0;
    end
    else
    begin
      poll_reg <= MACHINE_CYCLE;
    end
  end

  always_comb
  begin
    allowed = req.win_valid & ~ins_hi_reg & (req.win_high | ~ins_lo_reg);
    fire = (state_reg == TLVI_ARMED) & INSTR_BOUNDARY;
  end

  // a poll that finds nothing callable withdraws a waiting call,
  // so clearing an enable or the gate stops it if a poll comes before the boundary
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      TLVI_IDLE:
      begin
        if (poll_reg & allowed)
        begin
          state_next = TLVI_ARMED;
        end
      end
      TLVI_ARMED:
      begin
        if (fire)
        begin
          state_next = TLVI_IDLE;
        end
        else if (poll_reg & ~allowed)
        begin
          state_next = TLVI_IDLE;
        end
      end
      default: state_next = TLVI_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      state_reg <= TLVI_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // a later poll may replace the waiting winner with a better one
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      pend_src_reg <= 3'h0;
      pend_high_reg <= 1'b0;
    end
    else if (poll_reg & allowed & ~fire)
    begin
      pend_src_reg <= req.win_src;
      pend_high_reg <= req.win_high;
    end
  end

  // ==========================================================
  // in-service markers
  // the clear is applied first so a call on the same edge still sets
  always_comb
  begin
    ins_hi_next = ins_hi_reg;
    ins_lo_next = ins_lo_reg;
    if (RETURN_FROM_SERVICE)
    begin
      if (ins_hi_reg)
      begin
        ins_hi_next = 1'b0;
      end
      else
      begin
        ins_lo_next = 1'b0;
      end
    end
    if (fire)
    begin
      if (pend_high_reg)
      begin
        ins_hi_next = 1'b1;
      end
      else
      begin
        ins_lo_next = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ins_hi_reg <= 1'b0;
      ins_lo_reg <= 1'b0;
    end
    else
    begin
      ins_hi_reg <= ins_hi_next;
      ins_lo_reg <= ins_lo_next;
    end
  end

  // ==========================================================
  // call outputs toward the core and the peripherals
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      call_reg <= 1'b0;
    end
    else
    begin
      call_reg <= fire;
    end
  end

  // the ack lets a peripheral clear its own flag, so it must be one-hot
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ack_reg <= 7'h00;
    end
    else
    begin
      ack_reg <= fire ? 7'(7'h01 << pend_src_reg) : 7'h00;
    end
  end

  // the vector stays on the port until the next call
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      vector_reg <= 16'h0000;
      last_src_reg <= 3'h0;
    end
    else if (fire)
    begin
      vector_reg <= tlvi_vector(pend_src_reg);
      last_src_reg <= pend_src_reg;
    end
  end

  // ==========================================================
  // output drive
  assign READDATA = rdata_reg;
  assign WAITREQUEST = wait_reg;
  assign LONG_CALL = call_reg;
  assign VECTOR = vector_reg;
  assign SOURCE_ACK = ack_reg;
  assign IN_SERVICE_HIGH = ins_hi_reg;
  assign IN_SERVICE_LOW = ins_lo_reg;
endmodule : tlvi_unit
`default_nettype wire

// ---- dv/tlvi_core_model.sv ----
// behavioural model of the core side of the call link
`timescale 1ns/1ps
`default_nettype none
module tlvi_core_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic ret_req,
  output logic mc,
  output logic ib,
  output logic ret
);
  logic [2:0] cnt_reg;
  // ==========
  // strobes
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt_reg <= 3'h0;
      mc <= 1'b0;
      ib <= 1'b0;
      ret <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 3'h1;
      mc <= (cnt_reg[1:0] == 2'h3);
      // a slow core offers a boundary only once in eight clocks
      ib <= slow ? (cnt_reg == 3'h5) : 1'b1;
      ret <= ret_req;
    end
  end
endmodule : tlvi_core_model
`default_nettype wire

// ---- dv/tlvi_unit_props.sv ----
// concurrent checks on the interrupt unit ports
`timescale 1ns/1ps
`default_nettype none
module tlvi_unit_props
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic WAITREQUEST,
  input wire logic INSTR_BOUNDARY,
  input wire logic RETURN_FROM_SERVICE,
  input wire logic LONG_CALL,
  input wire logic [15:0] VECTOR,
  input wire logic [6:0] SOURCE_ACK,
  input wire logic IN_SERVICE_HIGH,
  input wire logic IN_SERVICE_LOW
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // ==========
  // checks
  wait_one_a:
    assert property (!WAITREQUEST |=> WAITREQUEST) else $error("wait low twice");
  wait_cause_a:
    assert property (!WAITREQUEST |-> $past(READ) || $past(WRITE)) else $error("idle answer");
  call_pulse_a:
    assert property (LONG_CALL |=> !LONG_CALL) else $error("call too long");
  call_boundary_a:
    assert property (LONG_CALL |-> $past(INSTR_BOUNDARY)) else $error("call off boundary");
  ack_onehot_a:
    assert property (LONG_CALL |-> $onehot(SOURCE_ACK)) else $error("ack not one-hot");
  ack_quiet_a:
    assert property (!LONG_CALL |-> SOURCE_ACK == 7'h00) else $error("stray ack");
  vector_hold_a:
    assert property (!LONG_CALL |-> $stable(VECTOR)) else $error("vector moved");
  call_marks_a:
    assert property (LONG_CALL |-> IN_SERVICE_HIGH || IN_SERVICE_LOW) else $error("no marker");
  high_blocks_a:
    assert property ($past(IN_SERVICE_HIGH) && !$past(RETURN_FROM_SERVICE) |-> !LONG_CALL)
      else $error("call in high service");
  twowire_vec_a:
    assert property (LONG_CALL && SOURCE_ACK[6] |-> VECTOR == 16'h003b) else $error("bad vector");
  cover property (LONG_CALL && IN_SERVICE_HIGH && IN_SERVICE_LOW);
  cover property (WRITE && !WAITREQUEST);
  cover property (READ && !WAITREQUEST);
endmodule : tlvi_unit_props
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench of the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tlvi_pkg::*;
  logic CLK = 0, RSTN = 0, READ = 0, WRITE = 0, ret_req = 0, slow = 0;
  logic [9:0] ADDRESS = '0;
  logic [3:0] BYTEENABLE = 4'h1;
  logic [31:0] WRITEDATA = '0;
  logic [31:0] READDATA;
  logic WAITREQUEST, LONG_CALL, IN_SERVICE_HIGH, IN_SERVICE_LOW, mc, ib, ret;
  logic [15:0] VECTOR, gv;
  logic [6:0] SOURCE_ACK, ga;
  logic [8:0] fl = '0;
  logic [7:0] q, me, ee, lm, le;
  int failures = 0, n_compared = 0, seed = 61748, nc;
  int vt[7] = '{3, 11, 19, 27, 35, 43, 59};
  initial forever #5 CLK = ~CLK;
  tlvi_core_model tlvi_core_model_i (.clk(CLK), .rstn(RSTN), .slow(slow), .ret_req(ret_req),
    .mc(mc), .ib(ib), .ret(ret));
  tlvi_unit tlvi_unit_i (.CLK(CLK), .RSTN(RSTN), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .PIN0_REQUEST_FLAG(fl[0]), .TIMER0_OVERFLOW_FLAG(fl[1]), .PIN1_REQUEST_FLAG(fl[2]),
    .TIMER1_OVERFLOW_FLAG(fl[3]), .RX_DONE_FLAG(fl[4]), .TX_DONE_FLAG(fl[5]),
    .TIMER2_OVERFLOW_FLAG(fl[6]), .TIMER2_EXTERNAL_FLAG(fl[7]), .TWO_WIRE_PORT_FLAG(fl[8]),
    .MACHINE_CYCLE(mc), .INSTR_BOUNDARY(ib), .RETURN_FROM_SERVICE(ret), .LONG_CALL(LONG_CALL),
    .VECTOR(VECTOR), .SOURCE_ACK(SOURCE_ACK), .IN_SERVICE_HIGH(IN_SERVICE_HIGH),
    .IN_SERVICE_LOW(IN_SERVICE_LOW));
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    WRITE <= wr;
    READ <= !wr;
    ADDRESS <= {idx, 2'b00};
    WRITEDATA <= {24'h0, d};
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (WAITREQUEST !== 1'b0 && n < 50);
    if (n >= 50) chk("bus", 16'h0, 16'h1);
    q = READDATA[7:0];
    WRITE <= 1'b0;
    READ <= 1'b0;
    @(posedge CLK);
  endtask : bus
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk("reg", {8'h0, e}, {8'h0, q});
  endtask : rd
  task automatic setr();
    bus(1'b1, IDX_ENA_MAIN, me);
    bus(1'b1, IDX_ENA_EXT, ee);
    bus(1'b1, IDX_LVL_MAIN, lm);
    bus(1'b1, IDX_LVL_EXT, le);
  endtask : setr
  task automatic rnd_regs();
    me = 8'($random(seed));
    ee = 8'($random(seed));
    lm = 8'($random(seed));
    le = 8'($random(seed));
    setr();
  endtask : rnd_regs
  // reference pick: high level first, then lowest source number
  function automatic int pick(input logic ish, input logic isl);
    logic r, en, hv;
    pick = -1;
    for (int lv = 1; lv >= 0; lv--)
      for (int i = 0; i < 7; i++)
      begin
        r = i < 4 ? fl[i] : i == 4 ? fl[4] | fl[5] : i == 5 ? fl[6] | fl[7] : fl[8];
        en = i < 6 ? me[i] : ee[1];
        hv = i < 6 ? lm[i] : le[1];
        if (r && en && me[7] && hv == lv && !ish && (lv == 1 || !isl) && pick < 0) pick = i;
      end
  endfunction : pick
  task automatic expect_call(input int w);
    nc = 0;
    repeat (40)
    begin
      @(posedge CLK);
      if (LONG_CALL === 1'b1)
      begin
        nc++;
        gv = VECTOR;
        ga = SOURCE_ACK;
      end
    end
    chk("calls", 16'(w >= 0), 16'(nc));
    if (w >= 0)
    begin
      chk("vector", 16'(vt[w]), gv);
      chk("ack", 16'(1 << w), {9'h0, ga});
    end
  endtask : expect_call
  // flags outside keep drop and are resampled before the return, so nothing stale re-arms
  task automatic retire(input logic [8:0] keep);
    fl <= keep;
    repeat (12) @(posedge CLK);
    ret_req <= 1'b1;
    @(posedge CLK);
    ret_req <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask : retire
  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end
  // ==========
  // sequence
  initial
  begin
    repeat (12) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    rd(IDX_ENA_MAIN, 8'h00);
    rd(IDX_ENA_EXT, 8'h00);
    rd(IDX_LVL_MAIN, 8'h00);
    rd(IDX_LVL_EXT, 8'h00);
    rd(8'hff, 8'h00);
    BYTEENABLE <= 4'h0;
    bus(1'b1, IDX_ENA_MAIN, 8'hff);
    BYTEENABLE <= 4'h1;
    rd(IDX_ENA_MAIN, 8'h00);
    repeat (4)
    begin
      rnd_regs();
      rd(IDX_ENA_MAIN, me & MAIN_MASK);
      rd(IDX_ENA_EXT, ee & EXT_MASK);
      rd(IDX_LVL_MAIN, lm & LVL_MASK);
      rd(IDX_LVL_EXT, le & EXT_MASK);
    end
    lm = 8'h00;
    le = 8'h00;
    for (int s = 0; s < 8; s++)
    begin
      me = s < 6 ? 8'h80 | 8'(1 << s) : s == 6 ? 8'h80 : 8'h3f;
      ee = s == 6 ? 8'h02 : 8'h00;
      setr();
      fl <= 9'h1ff;
      expect_call(s < 7 ? s : -1);
      rd(IDX_SAMPLES, 8'h7f);
      retire(9'h000);
    end
    slow <= 1'b1;
    repeat (16)
    begin
      rnd_regs();
      fl <= 9'($random(seed));
      @(posedge CLK);
      expect_call(pick(1'b0, 1'b0));
      retire(9'h000);
    end
    me = 8'h86;
    ee = 8'h00;
    lm = 8'h02;
    setr();
    fl <= 9'h004;
    expect_call(2);
    fl <= 9'h006;
    expect_call(1);
    chk("marks", 16'h3, {14'h0, IN_SERVICE_HIGH, IN_SERVICE_LOW});
    rd(IDX_STATUS, 8'h13);
    rd(IDX_SAMPLES, 8'h06);
    retire(9'h004);
    chk("marks", 16'h1, {14'h0, IN_SERVICE_HIGH, IN_SERVICE_LOW});
    expect_call(-1);
    retire(9'h000);
    chk("marks", 16'h0, {14'h0, IN_SERVICE_HIGH, IN_SERVICE_LOW});
    rd(IDX_STATUS, 8'h10);
    // a second reset in mid-run must bring the main enable and level registers and the vector back to zero
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    rd(IDX_ENA_MAIN, 8'h00);
    rd(IDX_LVL_MAIN, 8'h00);
    chk("vector", 16'h0, VECTOR);
    report_and_stop();
  end
endmodule : tb
bind tlvi_unit tlvi_unit_props tlvi_unit_props_i (.CLK(CLK), .RSTN(RSTN), .READ(READ),
  .WRITE(WRITE), .WAITREQUEST(WAITREQUEST), .INSTR_BOUNDARY(INSTR_BOUNDARY),
  .RETURN_FROM_SERVICE(RETURN_FROM_SERVICE), .LONG_CALL(LONG_CALL), .VECTOR(VECTOR),
  .SOURCE_ACK(SOURCE_ACK), .IN_SERVICE_HIGH(IN_SERVICE_HIGH), .IN_SERVICE_LOW(IN_SERVICE_LOW));
`default_nettype wire
